//--- rtl/iq_map.svh
// Constants of the instruction queue and decode front end.
// Included by the package; assumes nothing else.
`ifndef IQ_MAP_SVH
`define IQ_MAP_SVH
`define IQ_ENTRIES    18
`define IQ_PD_MAX     6
`define IQ_ISSUE_MAX  5
`define IQ_DECODERS   4
`define IQ_CPLX_MAX   4
`define IQ_SEQ_MAX    3
`define IQ_FIFO_DEPTH 16
`define IQ_ENT_W      16
`define IQ_GRP_W      64
`define IQ_PTR_RST    5'h00
`define IQ_SP_STEP32  8'h04
`define IQ_SP_STEP64  8'h08
`define E_TAG   6:0
`define E_UOPS  9:7
`define E_FUSE1 10
`define E_JCC   11
`define E_MFUSE 12
`define E_STK   15:13
`define R_VALID 15
`define R_MACRO 14
`define R_MICRO 13
`define R_UOPS  12:10
`define R_STK   9:7
`define R_TAG   6:0
`endif

//--- rtl/iq_pkg.sv
// Types and shared decode helpers of the instruction front end.
// Relies on iq_map.svh for field positions.
`include "iq_map.svh"
package iq_pkg;
  typedef logic [`IQ_ENT_W-1:0] entry_t;
  typedef enum logic [2:0] {
    STK_NONE  = 3'h0,
    STK_PUSH  = 3'h1,
    STK_POP   = 3'h2,
    STK_RET   = 3'h3,
    STK_CALL  = 3'h4,
    STK_LEAVE = 3'h5
  } stk_t;
  typedef enum logic [0:0] {
    ST_STREAM = 1'b0,
    ST_LOOP   = 1'b1
  } lock_t;

  // Micro-op count after micro-fusion and stack tracking
  function automatic logic [2:0] eff_uops(input entry_t e);
    logic [2:0] u;
    u = e[`E_UOPS];
    if (e[`E_STK] == STK_PUSH || e[`E_STK] == STK_POP ||
        e[`E_STK] == STK_RET)
    begin
      u = 3'h1;
    end
    else if (e[`E_MFUSE] && u > 3'h1)
    begin
      u = u - 3'h1;
    end
    if (u == 3'h0)
    begin
      u = 3'h1;
    end
    return u;
  endfunction
endpackage

//--- rtl/iq_group_fifo.sv
// Parameterised FIFO of decoded groups with a registered head word.
// Assumes DEPTH is a power of two; flush empties it in one cycle.
`timescale 1ns/1ns
module iq_group_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire logic             i_flush,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rd;
    logic [AW-1:0]               wr;
    logic [AW:0]                 cnt;
    logic                        ov;
    logic [WIDTH-1:0]            od;
  } fifo_st_t;
  fifo_st_t s_reg;
  fifo_st_t s_next;
  logic     push;
  logic     take;

  assign o_in_ready  = (s_reg.cnt != (AW+1)'(DEPTH));
  assign o_out_valid = s_reg.ov;
  assign o_out_data  = s_reg.od;

  always_comb
  begin
    s_next = s_reg;
    push   = i_in_valid && o_in_ready;
    take   = (!s_reg.ov || i_out_ready) && (s_reg.cnt != '0);
    if (s_reg.ov && i_out_ready)
    begin
      s_next.ov = 1'b0;
    end
    if (push)
    begin
      s_next.mem[s_reg.wr] = i_in_data;
      s_next.wr            = s_reg.wr + 1'b1;
    end
    if (take)
    begin
      s_next.od = s_reg.mem[s_reg.rd];
      s_next.ov = 1'b1;
      s_next.rd = s_reg.rd + 1'b1;
    end
    s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(take);
    if (i_flush)
    begin
      s_next.rd  = '0;
      s_next.wr  = '0;
      s_next.cnt = '0;
      s_next.ov  = 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end
endmodule

//--- rtl/iq_slot_decoder.sv
// One decoder slot: builds the micro-op record and stack delta.
// Steering upstream only hands single-uop flows to simple slots.
`timescale 1ns/1ns
`include "iq_map.svh"
module iq_slot_decoder #(
  parameter logic COMPLEX = 1'b0
) (
  input  wire logic                 i_valid,
  input  wire logic [`IQ_ENT_W-1:0] i_entry,
  input  wire logic                 i_fused,
  input  wire logic                 i_mode64,
  output logic [`IQ_ENT_W-1:0]      o_rec,
  output logic [7:0]                o_sp_delta
);
  always_comb
  begin
    logic [7:0] step;
    step       = i_mode64 ? `IQ_SP_STEP64 : `IQ_SP_STEP32;
    o_rec      = '0;
    o_sp_delta = 8'h00;
    if (i_valid)
    begin
      o_rec[`R_VALID] = 1'b1;
      o_rec[`R_TAG]   = i_entry[`E_TAG];
      o_rec[`R_STK]   = i_entry[`E_STK];
      o_rec[`R_MACRO] = i_fused;
      o_rec[`R_MICRO] = i_entry[`E_MFUSE];
      // Simple slot always yields one fused micro-op
      o_rec[`R_UOPS]  = (COMPLEX && !i_fused) ?
                        iq_pkg::eff_uops(i_entry) : 3'h1;
      unique case (i_entry[`E_STK])
        iq_pkg::STK_PUSH,
        iq_pkg::STK_CALL:  o_sp_delta = 8'h00 - step;
        iq_pkg::STK_POP,
        iq_pkg::STK_RET,
        iq_pkg::STK_LEAVE: o_sp_delta = step;
        default:           o_sp_delta = 8'h00;
      endcase
    end
  end
endmodule

//--- rtl/instr_queue_and_decode.sv
// Instruction queue with loop replay, four decoders and microsequencer.
// Predecode honours o_pd_ready; renamer drains o_grp_* with ready.
`timescale 1ns/1ns
`include "iq_map.svh"
module instr_queue_and_decode (
  input  wire logic                                i_clk,
  input  wire logic                                i_srst,
  input  wire logic                                i_mode64,
  input  wire logic [2:0]                          i_pd_count,
  input  wire logic [`IQ_PD_MAX*`IQ_ENT_W-1:0]     i_pd_data,
  output logic                                     o_pd_ready,
  input  wire logic                                i_lsd_lock,
  input  wire logic [4:0]                          i_lsd_len,
  input  wire logic                                i_mispredict,
  output logic                                     o_fetch_idle,
  output logic                                     o_grp_valid,
  output logic [`IQ_GRP_W-1:0]                     o_grp_data,
  input  wire logic                                i_grp_ready,
  output logic [7:0]                               o_sp_offset
);
  typedef struct packed {
    logic [`IQ_ENTRIES-1:0][`IQ_ENT_W-1:0] q;
    logic [4:0]                            rd;
    logic [4:0]                            wr;
    logic [4:0]                            cnt;
    iq_pkg::lock_t                         lock;
    logic [4:0]                            lk_start;
    logic [4:0]                            lk_len;
    logic [4:0]                            lk_off;
    logic [2:0]                            seq_left;
    logic [6:0]                            seq_tag;
    logic                                  pd_ready;
    logic                                  fetch_idle;
    logic [7:0]                            sp_off;
  } iq_st_t;

  iq_st_t                                 s_reg;
  iq_st_t                                 s_next;
  logic [`IQ_PD_MAX-1:0][`IQ_ENT_W-1:0]   win;
  logic [`IQ_PD_MAX-1:0]                  wav;
  logic [`IQ_DECODERS-1:0][`IQ_ENT_W-1:0] sl_ent;
  logic [`IQ_DECODERS-1:0]                sl_val;
  logic [`IQ_DECODERS-1:0]                sl_fus;
  logic [`IQ_DECODERS-1:0][`IQ_ENT_W-1:0] dec_rec;
  logic [`IQ_DECODERS-1:0][7:0]           dec_sp;
  logic [`IQ_GRP_W-1:0]                   grp;
  logic [2:0]                             n_used;
  logic [2:0]                             seq_chunk;
  logic                                   seq_go;
  logic                                   seq_emit;
  logic                                   issue_ok;
  logic                                   lock_take;
  logic                                   fifo_rdy;
  logic                                   grp_push;

  // Add modulo m; a below m, b small
  function automatic logic [4:0] wrap_add(input logic [4:0] a,
                                          input logic [4:0] b,
                                          input logic [4:0] m);
    logic [5:0] s;
    s = {1'b0, a} + {1'b0, b};
    for (int i = 0; i < `IQ_PD_MAX; i++)
    begin
      if (s >= {1'b0, m})
      begin
        s = s - {1'b0, m};
      end
    end
    return s[4:0];
  endfunction

  assign lock_take = i_lsd_lock && (s_reg.lock == iq_pkg::ST_STREAM) &&
                     (s_reg.seq_left == 3'h0) && (i_lsd_len != 5'h00) &&
                     (i_lsd_len < 5'(`IQ_ENTRIES)) &&
                     (i_lsd_len <= s_reg.cnt) && !i_mispredict;
  assign issue_ok  = fifo_rdy && (s_reg.seq_left == 3'h0) &&
                     !lock_take && !i_mispredict;
  assign seq_emit  = fifo_rdy && (s_reg.seq_left != 3'h0) && !i_mispredict;
  assign seq_chunk = (s_reg.seq_left > 3'(`IQ_SEQ_MAX)) ?
                     3'(`IQ_SEQ_MAX) : s_reg.seq_left;
  assign grp_push  = (|sl_val) || seq_emit;

  // Look-ahead window, from the head or around the locked loop
  always_comb
  begin
    logic [4:0] pos;
    pos = 5'h00;
    for (int k = 0; k < `IQ_PD_MAX; k++)
    begin
      if (s_reg.lock == iq_pkg::ST_LOOP)
      begin
        // Predecoded entries replay as is, no refetch
        pos    = wrap_add(s_reg.lk_start,
                          wrap_add(s_reg.lk_off, 5'(k), s_reg.lk_len),
                          5'(`IQ_ENTRIES));
        wav[k] = 1'b1;
      end
      else
      begin
        pos    = wrap_add(s_reg.rd, 5'(k), 5'(`IQ_ENTRIES));
        wav[k] = (5'(k) < s_reg.cnt);
      end
      win[k] = s_reg.q[pos];
    end
  end

  // Steering of window entries onto the four decoders
  always_comb
  begin
    logic [2:0] cur;
    logic [2:0] e;
    logic       stop;
    logic       fdone;
    cur    = 3'h0;
    e      = 3'h0;
    stop   = !issue_ok;
    fdone  = 1'b0;
    seq_go = 1'b0;
    sl_val = '0;
    sl_fus = '0;
    sl_ent = '0;
    for (int d = 0; d < `IQ_DECODERS; d++)
    begin
      if (!stop && cur < 3'(`IQ_PD_MAX) && wav[cur])
      begin
        e         = iq_pkg::eff_uops(win[cur]);
        sl_ent[d] = win[cur];
        if (e > 3'(`IQ_CPLX_MAX))
        begin
          stop = 1'b1;
          if (d == 0)
          begin
            seq_go = 1'b1;
            cur    = cur + 3'h1;
          end
        end
        else if (d != 0 && e != 3'h1)
        begin
          stop = 1'b1;
        end
        else
        begin
          sl_val[d] = 1'b1;
          if (!i_mode64 && !fdone && cur < 3'(`IQ_PD_MAX - 1) &&
              wav[cur + 3'h1] && win[cur][`E_FUSE1] &&
              win[cur + 3'h1][`E_JCC])
          begin
            sl_fus[d] = 1'b1;
            fdone     = 1'b1;
            cur       = cur + 3'h2;
          end
          else
          begin
            cur = cur + 3'h1;
          end
        end
      end
      else
      begin
        stop = 1'b1;
      end
    end
    n_used = cur;
  end

  for (genvar d = 0; d < `IQ_DECODERS; d++)
  begin : g_dec
    iq_slot_decoder #(
      .COMPLEX (d == 0)
    ) u_dec (
      .i_valid    (sl_val[d] || (seq_go && d == 0)),
      .i_entry    (sl_ent[d]),
      .i_fused    (sl_fus[d]),
      .i_mode64   (i_mode64),
      .o_rec      (dec_rec[d]),
      .o_sp_delta (dec_sp[d])
    );
  end

  // Group word; sequencer output takes slot 0
  always_comb
  begin
    grp = dec_rec;
    if (seq_emit)
    begin
      grp[`IQ_ENT_W-1:0]   = '0;
      grp[`R_VALID]        = 1'b1;
      grp[`R_UOPS]         = seq_chunk;
      grp[`R_TAG]          = s_reg.seq_tag;
    end
  end

  iq_group_fifo #(
    .WIDTH (`IQ_GRP_W),
    .DEPTH (`IQ_FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_srst      (i_srst),
    .i_flush     (i_mispredict),
    .i_in_valid  (grp_push),
    .i_in_data   (grp),
    .o_in_ready  (fifo_rdy),
    .o_out_valid (o_grp_valid),
    .o_out_data  (o_grp_data),
    .i_out_ready (i_grp_ready)
  );

  always_comb
  begin
    logic       wr_take;
    logic [4:0] add;
    s_next  = s_reg;
    wr_take = s_reg.pd_ready && (i_pd_count != 3'h0);
    add     = wr_take ? {2'b00, i_pd_count} : 5'h00;
    for (int k = 0; k < `IQ_PD_MAX; k++)
    begin
      if (wr_take && 3'(k) < i_pd_count)
      begin
        s_next.q[wrap_add(s_reg.wr, 5'(k), 5'(`IQ_ENTRIES))] =
          i_pd_data[k*`IQ_ENT_W +: `IQ_ENT_W];
      end
    end
    s_next.wr = wrap_add(s_reg.wr, add, 5'(`IQ_ENTRIES));
    if (s_reg.lock == iq_pkg::ST_LOOP)
    begin
      // Locked entries stay put; only the replay offset moves
      s_next.lk_off = wrap_add(s_reg.lk_off, {2'b00, n_used},
                               s_reg.lk_len);
      s_next.cnt    = s_reg.cnt + add;
    end
    else
    begin
      s_next.rd  = wrap_add(s_reg.rd, {2'b00, n_used}, 5'(`IQ_ENTRIES));
      s_next.cnt = s_reg.cnt + add - {2'b00, n_used};
    end
    if (lock_take)
    begin
      s_next.lock     = iq_pkg::ST_LOOP;
      s_next.lk_start = s_reg.rd;
      s_next.lk_len   = i_lsd_len;
      s_next.lk_off   = 5'h00;
    end
    if (seq_go)
    begin
      s_next.seq_left = iq_pkg::eff_uops(win[0]);
      s_next.seq_tag  = win[0][`E_TAG];
    end
    else if (seq_emit)
    begin
      s_next.seq_left = s_reg.seq_left - seq_chunk;
    end
    if ((|sl_val) || seq_go)
    begin
      s_next.sp_off = s_reg.sp_off + dec_sp[0] + dec_sp[1] +
                      dec_sp[2] + dec_sp[3];
    end
    if (i_mispredict)
    begin
      s_next.rd       = `IQ_PTR_RST;
      s_next.wr       = `IQ_PTR_RST;
      s_next.cnt      = 5'h00;
      s_next.lock     = iq_pkg::ST_STREAM;
      s_next.lk_off   = 5'h00;
      s_next.seq_left = 3'h0;
      s_next.sp_off   = 8'h00;
    end
    s_next.pd_ready   = (s_next.lock == iq_pkg::ST_STREAM) &&
                        (5'(`IQ_ENTRIES) - s_next.cnt >=
                         5'(`IQ_PD_MAX));
    s_next.fetch_idle = (s_next.lock == iq_pkg::ST_LOOP);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign o_pd_ready   = s_reg.pd_ready;
  assign o_fetch_idle = s_reg.fetch_idle;
  assign o_sp_offset  = s_reg.sp_off;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  AST_CNT_MAX: assert property (
    s_reg.cnt <= 5'(`IQ_ENTRIES))
    else $error("queue count above capacity");
  AST_ISSUE_MAX: assert property (
    n_used <= 3'(`IQ_ISSUE_MAX))
    else $error("more than five instructions issued");
  AST_ONE_FUSE: assert property (
    $countones(sl_fus) <= 1)
    else $error("two macro-fusions in one cycle");
  AST_LOCK_LEN: assert property (
    $rose(o_fetch_idle) |-> s_reg.lk_len < 5'(`IQ_ENTRIES))
    else $error("loop locked that does not fit");
  AST_LOCK_HOLD: assert property (
    s_reg.lock == iq_pkg::ST_LOOP && !i_mispredict
    |=> s_reg.lock == iq_pkg::ST_LOOP && $stable(s_reg.lk_start))
    else $error("loop lock lost without misprediction");
  AST_IDLE: assert property (
    s_reg.lock == iq_pkg::ST_LOOP |-> o_fetch_idle && !o_pd_ready)
    else $error("front end not idle during replay");
  AST_CPLX: assert property (
    sl_val[0] |-> iq_pkg::eff_uops(sl_ent[0]) <= 3'(`IQ_CPLX_MAX))
    else $error("complex decoder given a long flow");
  AST_SEQ: assert property (
    seq_go |=> s_reg.seq_left > 3'(`IQ_CPLX_MAX) ##1
    (s_reg.seq_left == $past(s_reg.seq_left) - 3'(`IQ_SEQ_MAX)) ||
    !$past(seq_emit) || $past(i_mispredict))
    else $error("sequencer rate wrong");
  AST_MODE64: assert property (
    i_mode64 |-> sl_fus == '0)
    else $error("macro-fusion in 64-bit mode");
  AST_BP: assert property (
    o_pd_ready |-> s_reg.cnt <= 5'(`IQ_ENTRIES - `IQ_PD_MAX))
    else $error("ready without room for a full write");
  AST_FLUSH: assert property (
    i_mispredict |=> s_reg.cnt == 5'h00 && !o_fetch_idle &&
    s_reg.seq_left == 3'h0 ##1 !o_grp_valid)
    else $error("misprediction did not clear the queue");
endmodule

//--- tb/front_far_side.sv
// Far-side model: predecode writer and renamer sink.
// Assumes tb_top fills pend and sets hold_sink and batch.
`timescale 1ns/1ns
module front_far_side (
  input  wire logic        i_clk,
  input  wire logic        i_pd_ready,
  output logic [2:0]       o_pd_count,
  output logic [95:0]      o_pd_data,
  output logic             o_grp_ready
);
  iq_pkg::entry_t pend[$];
  bit             hold_sink = 1'b0;
  int             batch     = 6;
  int             n;
  initial
  begin
    o_pd_count  = 3'h0;
    o_pd_data   = '0;
    o_grp_ready = 1'b0;
  end
  always @(posedge i_clk)
  begin
    if (i_pd_ready === 1'b1)
    begin
      repeat (o_pd_count)
        if (pend.size() != 0)
          void'(pend.pop_front());
    end
    #1;
    n = (pend.size() < batch) ? pend.size() : batch;
    o_pd_count <= 3'(n);
    // Unused lanes carry noise, not stale data
    for (int k = 0; k < 6; k++)
      o_pd_data[16*k +: 16] <= (k < n) ? pend[k] : 16'($random(tb_top.seed));
    o_grp_ready <= !hold_sink && ($random(tb_top.seed) % 4 != 0);
  end
endmodule

//--- tb/tb_top.sv
// Self-checking bench of the queue and decode block.
// Assumes iq_pkg and the far-side model are compiled first.
`timescale 1ns/1ns
`include "iq_map.svh"
module tb_top;
  logic        i_clk = 1'b0;
  logic        i_srst;
  logic        i_mode64;
  logic [2:0]  i_pd_count;
  logic [95:0] i_pd_data;
  logic        o_pd_ready;
  logic        i_lsd_lock;
  logic [4:0]  i_lsd_len;
  logic        i_mispredict;
  logic        o_fetch_idle;
  logic        o_grp_valid;
  logic [63:0] o_grp_data;
  logic        i_grp_ready;
  logic [7:0]  o_sp_offset;
  int          seed = 75477;
  int          errors = 0;
  int          num_checks = 0;
  int          ni;
  int          nf;
  int          loop_n = 0;
  bit          loop_mode = 1'b0;
  logic [15:0] exp_rec[$];
  logic [15:0] exp_msk[$];
  logic [6:0]  hist[$];
  logic [6:0]  prev;
  logic [6:0]  tag_n = 7'h00;
  logic [7:0]  exp_sp = 8'h00;
  logic [15:0] r;

  instr_queue_and_decode i_dut (
    .i_clk        (i_clk),
    .i_srst       (i_srst),
    .i_mode64     (i_mode64),
    .i_pd_count   (i_pd_count),
    .i_pd_data    (i_pd_data),
    .o_pd_ready   (o_pd_ready),
    .i_lsd_lock   (i_lsd_lock),
    .i_lsd_len    (i_lsd_len),
    .i_mispredict (i_mispredict),
    .o_fetch_idle (o_fetch_idle),
    .o_grp_valid  (o_grp_valid),
    .o_grp_data   (o_grp_data),
    .i_grp_ready  (i_grp_ready),
    .o_sp_offset  (o_sp_offset)
  );
  front_far_side p (
    .i_clk       (i_clk),
    .i_pd_ready  (o_pd_ready),
    .o_pd_count  (i_pd_count),
    .o_pd_data   (i_pd_data),
    .o_grp_ready (i_grp_ready)
  );

  initial
    forever #4 i_clk = ~i_clk;

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input bit ok, input string msg);
    num_checks++;
    if (!ok)
    begin
      errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic put(input logic [15:0] rec, input logic [15:0] m);
    exp_rec.push_back(rec);
    exp_msk.push_back(m);
  endtask

  // Queue one entry for predecode; model its records and stack step
  task automatic add(input logic [8:0] f, input bit rec);
    iq_pkg::entry_t e;
    int             u;
    logic [7:0]     step;
    e = {f, tag_n};
    tag_n++;
    p.pend.push_back(e);
    step = i_mode64 ? `IQ_SP_STEP64 : `IQ_SP_STEP32;
    u = e[`E_UOPS];
    if (e[`E_STK] inside {3'h1, 3'h2, 3'h3})
      u = 1;
    else if (e[`E_MFUSE] && u > 1)
      u--;
    if (u == 0)
      u = 1;
    if (e[`E_STK] inside {3'h1, 3'h4})
      exp_sp -= step;
    if (e[`E_STK] inside {3'h2, 3'h3, 3'h5})
      exp_sp += step;
    if (rec && u > 4)
      for (int c = u; c > 0; c -= 3)
        put({3'h4, 3'(c > 3 ? 3 : c), 3'h0, e[6:0]}, 16'hFFFF);
    else if (rec)
      put({2'b10, e[`E_MFUSE], 3'(u), e[`E_STK], e[6:0]},
          16'hFFFF);
  endtask

  task automatic got(input logic [15:0] g);
    logic [15:0] m;
    if (loop_mode)
    begin
      if (loop_n != 0)
        check(g[6:0] === hist[hist.size()-3], "replay order");
      else if (g[6:0] !== prev + 7'h1)
        check(g[6:0] === prev - 7'h2, "loop start");
      if (loop_n != 0 || g[6:0] !== prev + 7'h1)
        loop_n++;
      hist.push_back(g[6:0]);
      prev = g[6:0];
    end
    else if (exp_rec.size() == 0)
      check(1'b0, "extra record");
    else
    begin
      m = exp_msk.pop_front();
      check((g & m) === (exp_rec.pop_front() & m), "record");
    end
  endtask

  always @(posedge i_clk)
  begin
    if (o_grp_valid === 1'b1 && i_grp_ready === 1'b1)
    begin
      ni = 0;
      nf = 0;
      for (int d = 0; d < 4; d++)
      begin
        r = o_grp_data[16*d +: 16];
        if (r[15] === 1'b1)
        begin
          ni += 1 + r[14];
          nf += r[14];
          got(r);
        end
      end
      check(ni <= 5 && nf <= 1, "group too wide");
    end
  end

  task automatic drain;
    for (int i = 0; i < 2000 && exp_rec.size() != 0; i++)
      @(posedge i_clk);
    #1;
    check(exp_rec.size() == 0, "records missing");
  endtask

  task automatic flush;
    p.pend.delete();
    i_mispredict = 1'b1;
    @(posedge i_clk);
    #1;
    i_mispredict = 1'b0;
    loop_mode = 1'b0;
    exp_sp = 8'h00;
    check(o_grp_valid === 1'b0 && o_fetch_idle === 1'b0 &&
          o_sp_offset === 8'h00, "flush");
  endtask

  task automatic lock(input logic [4:0] len);
    i_lsd_len = len;
    i_lsd_lock = 1'b1;
    @(posedge i_clk);
    #1;
    i_lsd_lock = 1'b0;
    @(posedge i_clk);
    #1;
  endtask

  initial
  begin
    repeat (20000) @(posedge i_clk);
    errors++;
    report_and_stop();
  end

  initial
  begin
    i_srst = 1'b1;
    i_mode64 = 1'b0;
    i_lsd_lock = 1'b0;
    i_lsd_len = 5'h00;
    i_mispredict = 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
    i_srst = 1'b0;
    for (int m = 0; m < 2; m++)
    begin
      i_mode64 = m[0];
      for (int i = 0; i < 60; i++)
      begin
        p.batch = 1 + $unsigned($random(seed)) % 6;
        add({3'($unsigned($random(seed)) % 6), 2'($random(seed)), 1'b0,
             3'($random(seed))}, 1'b1);
      end
      drain();
      check(o_sp_offset === exp_sp, "stack offset");
      flush();
    end
    p.batch = 6;
    for (int m = 0; m < 2; m++)
    begin
      i_mode64 = m[0];
      if (m == 0)
        put({9'h188, tag_n}, 16'hFFFF);
      add(9'h009, m[0]);
      add(9'h011, m[0]);
      add(9'h009, 1'b1);
      add(9'h011, 1'b1);
      drain();
    end
    // Stall the sink so the queue fills, then lock a short loop
    p.hold_sink = 1'b1;
    loop_mode = 1'b1;
    prev = tag_n - 7'h1;
    for (int i = 0; i < 100; i++)
      add(9'h001, 1'b0);
    repeat (150) @(posedge i_clk);
    #1;
    check(o_pd_ready === 1'b0, "no back-pressure");
    lock(5'd18);
    check(o_fetch_idle === 1'b0, "long loop locked");
    lock(5'd3);
    check(o_fetch_idle === 1'b1 && o_pd_ready === 1'b0, "lock");
    p.hold_sink = 1'b0;
    repeat (80) @(posedge i_clk);
    #1;
    check(loop_n > 20, "replay stalled");
    flush();
    report_and_stop();
  end
endmodule
